/* rtl/ara_map.svh */
// Register offsets, field positions, reset values and timing values in ns of the
// result accumulator. Included by bare name; holds definitions only.
`ifndef ARA_MAP_SVH
`define ARA_MAP_SVH
`define ARA_OFF_CONFIG      8'hBC
`define ARA_OFF_RESULT_LOW  8'hBD
`define ARA_OFF_RESULT_HIGH 8'hBE
`define ARA_OFF_CONTROL     8'hE8
`define ARA_OFF_IRQ_STATUS  8'hC0
`define ARA_OFF_IRQ_CLEAR   8'hC1
`define ARA_OFF_IRQ_ENABLE  8'hC2
`define ARA_CFG_DIV_MSB     7
`define ARA_CFG_DIV_LSB     3
`define ARA_CFG_RPT_MSB     2
`define ARA_CFG_RPT_LSB     1
`define ARA_CFG_GAIN_BIT    0
`define ARA_CTL_BURST_BIT   6
`define ARA_CTL_DONE_BIT    5
`define ARA_CTL_BUSY_BIT    4
`define ARA_CTL_WIN_BIT     3
`define ARA_CTL_LJST_BIT    2
`define ARA_IRQ_DONE_BIT    0
`define ARA_IRQ_WIN_BIT     1
`define ARA_CONFIG_RESET    8'hF8
`define ARA_CONTROL_RESET   8'h00
`define ARA_RESULT_RESET    8'h00
`define ARA_BURST_GAP_NS    100
`define ARA_CLK_PERIOD_NS   10
`endif

/* rtl/ara_pkg.sv */
// Types shared by the result accumulator files.
// Assumes the map header supplies all numeric constants.
package ara_pkg;
    typedef enum logic [1:0] {
        ARA_RPT_1  = 2'h0,
        ARA_RPT_4  = 2'h1,
        ARA_RPT_8  = 2'h2,
        ARA_RPT_16 = 2'h3
    } ara_rpt_type;

    typedef enum logic [2:0] {
        ARA_ST_IDLE = 3'h1,
        ARA_ST_WAIT = 3'h2,
        ARA_ST_GAP  = 3'h4
    } ara_state_type;
endpackage : ara_pkg

/* rtl/ara_format.sv */
// Result formatter: maps the accumulated sum onto the high and low data bytes.
// Assumes a 16-bit sum and a justification select from the same clock domain.
`timescale 1ns/1ps
module ara_format (
    input  wire logic [15:0]         sum,
    input  wire ara_pkg::ara_rpt_type rpt,
    input  wire logic                ljst,
    output logic      [7:0]          res_high,
    output logic      [7:0]          res_low
);
    import ara_pkg::*;

    always_comb begin
        if (ljst) begin
            res_high = sum[11:4];
            res_low  = {sum[3:0], 4'h0};
        end else begin
            res_low = sum[7:0];
            case (rpt)
                ARA_RPT_1:  res_high = {4'h0, sum[11:8]};
                ARA_RPT_4:  res_high = {3'h0, sum[13:9]};
                ARA_RPT_8:  res_high = {2'h0, sum[14:9]};
                ARA_RPT_16: res_high = sum[15:8];
                default:    res_high = sum[15:8];
            endcase
        end
    end
endmodule : ara_format

/* rtl/ara_accum.sv */
// Result accumulator: repeat counting, burst sequencing, summing, result
// registers, interrupt flags and the register port.
// Assumes conversion results arrive with a one-cycle done pulse on REF_CLK and
// that start requests are already synchronous to REF_CLK.
`timescale 1ns/1ps
`include "ara_map.svh"
module ara_accum #(
    parameter int RESULT_WIDTH = 12
) (
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    input  wire logic [7:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR_STB,
    input  wire logic        RD_STB,
    output logic      [7:0]  RDATA,
    input  wire logic        CONV_START,
    output logic             CONV_TRIGGER,
    input  wire logic        CONV_DONE,
    input  wire logic [11:0] CONV_RESULT,
    input  wire logic        WINDOW_HIT,
    output logic             CONV_DONE_IRQ,
    output logic             WINDOW_CMP_IRQ,
    output logic             IRQ,
    output logic             BURST_MODE_EN,
    output logic             GAIN_PROGRAM_EN,
    output logic [4:0]       SAR_CLOCK_DIVIDER
);
    import ara_pkg::*;

    // ********************************************************************
    // Constants and elaboration check
    // ********************************************************************
    localparam int GAP_CYC_INT = `ARA_BURST_GAP_NS / `ARA_CLK_PERIOD_NS;
    localparam logic [3:0] GAP_CYC = (GAP_CYC_INT < 1) ? 4'h1 : 4'(GAP_CYC_INT);

    if (RESULT_WIDTH != 12) begin : g_width_check
        $error("ara_accum serves a 12-bit converter result only.");
    end

    // ********************************************************************
    // State
    // ********************************************************************
    logic [7:0]    cfg_reg,   cfg_next;
    logic [7:0]    ctl_reg,   ctl_next;
    logic [15:0]   sum_reg,   sum_next;
    logic [7:0]    high_reg,  high_next;
    logic [7:0]    low_reg,   low_next;
    logic [4:0]    cnt_reg,   cnt_next;
    logic [3:0]    gap_reg,   gap_next;
    ara_state_type st_reg,    st_next;
    logic          trig_reg,  trig_next;
    logic [1:0]    sts_reg,   sts_next;
    logic [1:0]    ien_reg,   ien_next;
    logic          irq_reg,   irq_next;
    logic [7:0]    rd_reg,    rd_next;
    logic [4:0]    target;
    logic [15:0]   sum_add;
    logic [7:0]    fmt_high;
    logic [7:0]    fmt_low;
    logic          seq_end;
    ara_rpt_type   rpt;
    logic          burst;
    logic          ljst;

    assign rpt   = ara_rpt_type'(cfg_reg[`ARA_CFG_RPT_MSB:`ARA_CFG_RPT_LSB]);
    assign burst = ctl_reg[`ARA_CTL_BURST_BIT];
    assign ljst  = ctl_reg[`ARA_CTL_LJST_BIT];

    // ********************************************************************
    // Repeat count decode
    // ********************************************************************
    always_comb begin
        case (rpt)
            ARA_RPT_1:  target = 5'h01;
            ARA_RPT_4:  target = 5'h04;
            ARA_RPT_8:  target = 5'h08;
            ARA_RPT_16: target = 5'h10;
            default:    target = 5'h01;
        endcase
    end

    // The first conversion of a sequence loads instead of adding.
    assign sum_add = ((cnt_reg == 5'h00) ? 16'h0000 : sum_reg)
                   + {4'h0, CONV_RESULT};
    assign seq_end = CONV_DONE && ((cnt_reg + 5'h01) == target);

    ara_format u_format (
        .sum      (sum_add),
        .rpt      (rpt),
        .ljst     (ljst),
        .res_high (fmt_high),
        .res_low  (fmt_low)
    );

    // ********************************************************************
    // Sequencer and accumulator
    // ********************************************************************
    always_comb begin
        st_next   = st_reg;
        cnt_next  = cnt_reg;
        sum_next  = sum_reg;
        gap_next  = gap_reg;
        trig_next = 1'b0;
        high_next = high_reg;
        low_next  = low_reg;
        case (st_reg)
            ARA_ST_IDLE: begin
                if (CONV_START) begin
                    trig_next = 1'b1;
                    st_next   = ARA_ST_WAIT;
                end
            end
            ARA_ST_WAIT: begin
                if (CONV_DONE) begin
                    sum_next = sum_add;
                    if (seq_end) begin
                        cnt_next  = 5'h00;
                        high_next = fmt_high;
                        low_next  = fmt_low;
                        st_next   = ARA_ST_IDLE;
                    end else begin
                        cnt_next = cnt_reg + 5'h01;
                        if (burst) begin
                            gap_next = GAP_CYC;
                            st_next  = ARA_ST_GAP;
                        end else begin
                            st_next = ARA_ST_IDLE;
                        end
                    end
                end
            end
            ARA_ST_GAP: begin
                // Self-timed restart; further start requests are ignored.
                if (gap_reg == 4'h1) begin
                    trig_next = 1'b1;
                    st_next   = ARA_ST_WAIT;
                end else begin
                    gap_next = gap_reg - 4'h1;
                end
            end
            default: begin
                st_next  = ARA_ST_IDLE;
                cnt_next = 5'h00;
            end
        endcase
        // Software writes to the data bytes land directly.
        if (WR_STB && ADDR == `ARA_OFF_RESULT_HIGH) begin
            high_next = WDATA;
        end
        if (WR_STB && ADDR == `ARA_OFF_RESULT_LOW) begin
            low_next = WDATA;
        end
    end

    // ********************************************************************
    // Registers, flags and read port
    // ********************************************************************
    always_comb begin
        cfg_next = cfg_reg;
        ctl_next = ctl_reg;
        sts_next = sts_reg;
        ien_next = ien_reg;
        if (WR_STB) begin
            case (ADDR)
                `ARA_OFF_CONFIG:     cfg_next = WDATA;
                `ARA_OFF_CONTROL:    ctl_next = WDATA;
                `ARA_OFF_IRQ_CLEAR:  sts_next = sts_reg & ~WDATA[1:0];
                `ARA_OFF_IRQ_ENABLE: ien_next = WDATA[1:0];
                default: ;
            endcase
        end
        // Hardware set wins over a clear in the same cycle.
        if (seq_end && st_reg == ARA_ST_WAIT) begin
            ctl_next[`ARA_CTL_DONE_BIT] = 1'b1;
            sts_next[`ARA_IRQ_DONE_BIT] = 1'b1;
            if (WINDOW_HIT) begin
                ctl_next[`ARA_CTL_WIN_BIT] = 1'b1;
                sts_next[`ARA_IRQ_WIN_BIT] = 1'b1;
            end
        end
        ctl_next[`ARA_CTL_BUSY_BIT] = (st_next != ARA_ST_IDLE);
        irq_next = |(sts_next & ien_next);
        rd_next  = 8'h00;
        if (RD_STB) begin
            case (ADDR)
                `ARA_OFF_CONFIG:      rd_next = cfg_reg;
                `ARA_OFF_CONTROL:     rd_next = ctl_reg;
                `ARA_OFF_RESULT_HIGH: rd_next = high_reg;
                `ARA_OFF_RESULT_LOW:  rd_next = low_reg;
                `ARA_OFF_IRQ_STATUS:  rd_next = {6'h00, sts_reg};
                `ARA_OFF_IRQ_ENABLE:  rd_next = {6'h00, ien_reg};
                default:              rd_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_reg  <= `ARA_CONFIG_RESET;
            ctl_reg  <= `ARA_CONTROL_RESET;
            sum_reg  <= 16'h0000;
            high_reg <= `ARA_RESULT_RESET;
            low_reg  <= `ARA_RESULT_RESET;
            cnt_reg  <= 5'h00;
            gap_reg  <= 4'h0;
            st_reg   <= ARA_ST_IDLE;
            trig_reg <= 1'b0;
            sts_reg  <= 2'h0;
            ien_reg  <= 2'h0;
            irq_reg  <= 1'b0;
            rd_reg   <= 8'h00;
        end else begin
            cfg_reg  <= cfg_next;
            ctl_reg  <= ctl_next;
            sum_reg  <= sum_next;
            high_reg <= high_next;
            low_reg  <= low_next;
            cnt_reg  <= cnt_next;
            gap_reg  <= gap_next;
            st_reg   <= st_next;
            trig_reg <= trig_next;
            sts_reg  <= sts_next;
            ien_reg  <= ien_next;
            irq_reg  <= irq_next;
            rd_reg   <= rd_next;
        end
    end

    assign RDATA             = rd_reg;
    assign CONV_TRIGGER      = trig_reg;
    assign CONV_DONE_IRQ     = ctl_reg[`ARA_CTL_DONE_BIT];
    assign WINDOW_CMP_IRQ    = ctl_reg[`ARA_CTL_WIN_BIT];
    assign IRQ               = irq_reg;
    assign BURST_MODE_EN     = ctl_reg[`ARA_CTL_BURST_BIT];
    assign GAIN_PROGRAM_EN   = cfg_reg[`ARA_CFG_GAIN_BIT];
    assign SAR_CLOCK_DIVIDER = cfg_reg[`ARA_CFG_DIV_MSB:`ARA_CFG_DIV_LSB];
endmodule : ara_accum

/* tb/ara_accum_monitor.sv */
// Port checker for the result accumulator, bound onto ara_accum.
// Assumes one REF_CLK domain, reset only through RSTN.
`timescale 1ns/1ps
module ara_accum_monitor (
    input wire logic       REF_CLK,
    input wire logic       RSTN,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR_STB,
    input wire logic       CONV_START,
    input wire logic       CONV_TRIGGER,
    input wire logic       CONV_DONE,
    input wire logic       CONV_DONE_IRQ,
    input wire logic       WINDOW_CMP_IRQ,
    input wire logic       IRQ,
    input wire logic       BURST_MODE_EN,
    input wire logic       GAIN_PROGRAM_EN,
    input wire logic [4:0] SAR_CLOCK_DIVIDER
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    AST_START_TRIG: assert property (CONV_TRIGGER && !BURST_MODE_EN |-> $past(CONV_START))
        else $error("Trigger without start.");
    AST_TRIG_PULSE: assert property (CONV_TRIGGER |=> !CONV_TRIGGER)
        else $error("Trigger longer than one cycle.");
    AST_BURST_GAP: assert property (BURST_MODE_EN && CONV_TRIGGER && !$past(CONV_START)
        |-> $past(CONV_DONE, 10) || $past(CONV_DONE, 11)) else $error("Burst gap wrong.");
    AST_BURST_QUIET: assert property (BURST_MODE_EN && CONV_TRIGGER |=> !CONV_TRIGGER [*8])
        else $error("Burst trigger too soon.");
    AST_CFG_FIELDS: assert property (WR_STB && ADDR == 8'hBC
        |=> SAR_CLOCK_DIVIDER == $past(WDATA[7:3]) && GAIN_PROGRAM_EN == $past(WDATA[0]))
        else $error("Config outputs wrong.");
    AST_BURST_BIT: assert property (WR_STB && ADDR == 8'hE8
        |=> BURST_MODE_EN == $past(WDATA[6])) else $error("Burst output wrong.");
    AST_DONE_FLAG: assert property ($rose(CONV_DONE_IRQ)
        |-> $past(CONV_DONE) || $past(CONV_DONE, 2)) else $error("Done flag without done.");
    AST_WIN_FLAG: assert property ($rose(WINDOW_CMP_IRQ)
        |-> $past(CONV_DONE) || $past(CONV_DONE, 2)) else $error("Window flag without done.");
    AST_IRQ_CAUSE: assert property ($rose(IRQ) |-> $past(CONV_DONE) || $past(CONV_DONE, 2)
        || $past(WR_STB) || $past(WR_STB, 2)) else $error("Interrupt without cause.");
endmodule : ara_accum_monitor

bind ara_accum ara_accum_monitor ara_accum_monitor_i (.REF_CLK(REF_CLK), .RSTN(RSTN),
    .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB), .CONV_START(CONV_START),
    .CONV_TRIGGER(CONV_TRIGGER), .CONV_DONE(CONV_DONE), .CONV_DONE_IRQ(CONV_DONE_IRQ),
    .WINDOW_CMP_IRQ(WINDOW_CMP_IRQ), .IRQ(IRQ), .BURST_MODE_EN(BURST_MODE_EN),
    .GAIN_PROGRAM_EN(GAIN_PROGRAM_EN), .SAR_CLOCK_DIVIDER(SAR_CLOCK_DIVIDER));

/* tb/ara_accum_test.sv */
// Self-checking bench for the result accumulator.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
module ara_accum_test;
    logic        REF_CLK = 1'b0;
    logic        RSTN = 1'b0;
    logic [7:0]  ADDR = 8'h00;
    logic [7:0]  WDATA = 8'h00;
    logic        WR_STB = 1'b0;
    logic        RD_STB = 1'b0;
    logic        CONV_START = 1'b0;
    logic        CONV_DONE = 1'b0;
    logic [11:0] CONV_RESULT = 12'h000;
    logic        WINDOW_HIT = 1'b0;
    logic [7:0]  RDATA;
    logic        CONV_TRIGGER, CONV_DONE_IRQ, WINDOW_CMP_IRQ, IRQ, BURST_MODE_EN, GAIN_PROGRAM_EN;
    logic [4:0]  SAR_CLOCK_DIVIDER;
    logic [15:0] sum;
    int          errors = 0;
    int          samples_checked = 0;
    int          c;
    always #5 REF_CLK = ~REF_CLK;
    ara_accum ara_accum_i (.REF_CLK(REF_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
        .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .CONV_START(CONV_START),
        .CONV_TRIGGER(CONV_TRIGGER), .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT),
        .WINDOW_HIT(WINDOW_HIT), .CONV_DONE_IRQ(CONV_DONE_IRQ), .WINDOW_CMP_IRQ(WINDOW_CMP_IRQ),
        .IRQ(IRQ), .BURST_MODE_EN(BURST_MODE_EN), .GAIN_PROGRAM_EN(GAIN_PROGRAM_EN),
        .SAR_CLOCK_DIVIDER(SAR_CLOCK_DIVIDER));
    // ****************
    // Tasks
    // ****************
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Expected high byte per repeat code, taken from the layout of the data pair.
    function automatic logic [7:0] exp_high(input int code, input logic [15:0] s);
        case (code)
            0:       exp_high = {4'h0, s[11:8]};
            1:       exp_high = {3'h0, s[13:9]};
            2:       exp_high = {2'h0, s[14:9]};
            default: exp_high = s[15:8];
        endcase
    endfunction : exp_high
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR_STB <= 1'b1;
        @(posedge REF_CLK);
        WR_STB <= 1'b0;
        @(posedge REF_CLK);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        ADDR <= a;
        RD_STB <= 1'b1;
        @(posedge REF_CLK);
        RD_STB <= 1'b0;
        #1;
        chk(nm, e, RDATA);
        @(posedge REF_CLK);
    endtask : rd
    // Results step down per conversion so a lost or repeated term shows in the sum.
    task automatic run(input int n, input logic burst, input logic [11:0] v0);
        int t;
        sum = 16'h0000;
        for (int k = 0; k < n; k++) begin
            if (!burst || k == 0) begin
                @(posedge REF_CLK);
                CONV_START <= 1'b1;
                @(posedge REF_CLK);
                CONV_START <= 1'b0;
            end
            for (t = 0; t < 40 && CONV_TRIGGER !== 1'b1; t++) @(posedge REF_CLK);
            if (t == 40) begin
                errors++;
                final_report();
            end
            if (k == n - 1) chk("early flag", 8'h00, {7'h0, CONV_DONE_IRQ});
            CONV_DONE <= 1'b1;
            CONV_RESULT <= v0 - k[11:0];
            sum = sum + (v0 - k[11:0]);
            @(posedge REF_CLK);
            CONV_DONE <= 1'b0;
        end
        repeat (4) @(posedge REF_CLK);
    endtask : run
    // ****************
    // Sequence
    // ****************
    initial begin
        repeat (16) @(posedge REF_CLK);
        RSTN <= 1'b1;
        @(posedge REF_CLK);
        rd(8'hBD, 8'h00, "result_low");
        rd(8'hBE, 8'h00, "result_high");
        rd(8'hBC, 8'hF8, "config");
        rd(8'hE8, 8'h00, "control");
        rd(8'h10, 8'h00, "unmapped");
        $display("Reset test done");
        wr(8'hC2, 8'h01);
        for (c = 0; c < 4; c++) begin
            wr(8'hBC, {5'h0A, c[1:0], 1'b1});
            run((c == 0) ? 1 : (2 << c), 1'b0, 12'hFFF);
            chk("done flag", 8'h01, {7'h0, CONV_DONE_IRQ});
            chk("window flag", 8'h00, {7'h0, WINDOW_CMP_IRQ});
            chk("divider", 8'h0A, {3'h0, SAR_CLOCK_DIVIDER});
            chk("gain", 8'h01, {7'h0, GAIN_PROGRAM_EN});
            rd(8'hBE, exp_high(c, sum), "result_high");
            rd(8'hBD, sum[7:0], "result_low");
            chk("irq", 8'h01, {7'h0, IRQ});
            wr(8'hC1, 8'h01);
            wr(8'hE8, 8'h00);
            rd(8'hC0, 8'h00, "status");
            chk("irq clear", 8'h00, {7'h0, IRQ});
        end
        $display("Repeat test done");
        wr(8'hE8, 8'h40);
        wr(8'hBC, 8'h52);
        WINDOW_HIT <= 1'b1;
        run(4, 1'b1, 12'h123);
        WINDOW_HIT <= 1'b0;
        chk("window flag", 8'h01, {7'h0, WINDOW_CMP_IRQ});
        chk("burst pin", 8'h01, {7'h0, BURST_MODE_EN});
        rd(8'hBE, exp_high(1, sum), "burst high");
        rd(8'hBD, sum[7:0], "burst low");
        rd(8'hC0, 8'h03, "status");
        rd(8'hE8, 8'h68, "control");
        $display("Burst test done");
        wr(8'hC1, 8'h03);
        wr(8'hC2, 8'h00);
        wr(8'hBC, 8'h50);
        wr(8'hE8, 8'h04);
        run(1, 1'b0, 12'hABC);
        rd(8'hBE, 8'hAB, "left high");
        rd(8'hBD, 8'hC0, "left low");
        chk("masked irq", 8'h00, {7'h0, IRQ});
        $display("Justify test done");
        final_report();
    end
endmodule : ara_accum_test
